// File: design/pwsr_top.sv
`default_nettype none

module pwsr_top
    import pwsr_pkg::*;
#(
    parameter int NUM_PINS = 4
)
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [NUM_PINS-1:0] wake_pin,
    input  wire logic                rtc_wake_evt,
    input  wire logic                lvd_comp_async,
    input  wire logic                standby_in,
    output logic      [NUM_PINS-1:0] wake_pin_pulldown_en,
    output logic                     lvd_run,
    output logic                     sys_wake,
    output logic                     irq
);

    if (NUM_PINS != PWSR_NUM_PINS)
    begin : g_bad_pins
        $error("pwsr_top serves exactly four wakeup pins");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    pwsr_sync_if #(.W(NUM_PINS + 1)) sync_bus ();

    logic [NUM_PINS-1:0] pins_s;
    logic                lvd_s;

    assign sync_bus.async_bits = {lvd_comp_async, wake_pin};

    pwsr_sync #(.W(NUM_PINS + 1)) u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (sync_bus.sync)
    );

    assign pins_s = sync_bus.sync_bits[NUM_PINS-1:0];
    assign lvd_s  = sync_bus.sync_bits[NUM_PINS];

    // ****************************************************************
    // Bus address phase capture
    // ****************************************************************
    logic        dp_valid_r;
    logic        dp_valid_nxt;
    logic        dp_write_r;
    logic        dp_write_nxt;
    logic [7:0]  dp_addr_r;
    logic [7:0]  dp_addr_nxt;
    logic [1:0]  dp_lanes_r;
    logic [1:0]  dp_lanes_nxt;
    logic        addr_ok;
    logic [1:0]  lanes;

    assign addr_ok = hsel && htrans[1] && hready;

    always_comb
    begin
        if (hsize == PWSR_HSIZE_WORD)
            lanes = PWSR_LANES_ALL;
        else if (hsize == PWSR_HSIZE_HALF)
            lanes = haddr[1] ? PWSR_LANES_HI : PWSR_LANES_LO;
        else
            lanes = PWSR_LANES_NONE;
        dp_valid_nxt = addr_ok;
        dp_write_nxt = addr_ok ? hwrite : dp_write_r;
        dp_addr_nxt  = addr_ok ? (haddr[7:0] & PWSR_WORD_MASK) : dp_addr_r;
        dp_lanes_nxt = addr_ok ? lanes : dp_lanes_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r  <= 8'h00;
            dp_lanes_r <= PWSR_LANES_NONE;
        end
        else
        begin
            dp_valid_r <= dp_valid_nxt;
            dp_write_r <= dp_write_nxt;
            dp_addr_r  <= dp_addr_nxt;
            dp_lanes_r <= dp_lanes_nxt;
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic                     wr_lo;
    logic                     wr_ctl;
    logic                     wr_sts;
    logic                     wr_ist;
    logic                     wr_imk;
    logic                     clr_wake;
    logic                     clr_stb;
    logic [NUM_PINS-1:0]      gated;
    logic [NUM_PINS-1:0]      pin_evt;
    logic                     wake_evt;
    logic                     stb_evt;
    logic                     lvd_evt;
    logic [PWSR_NUM_IRQ-1:0]  evts;
    logic [NUM_PINS-1:0]      pin_en_r;
    logic [NUM_PINS-1:0]      pin_en_nxt;
    logic [NUM_PINS-1:0]      gated_prev_r;
    logic [NUM_PINS-1:0]      gated_prev_nxt;
    logic                     wake_flag_r;
    logic                     wake_flag_nxt;
    logic                     stb_flag_r;
    logic                     stb_flag_nxt;
    logic                     stb_prev_r;
    logic                     stb_prev_nxt;
    logic                     lvd_flag_r;
    logic                     lvd_flag_nxt;
    logic                     sys_wake_r;
    logic                     sys_wake_nxt;
    logic [PWSR_NUM_IRQ-1:0]  int_stat_r;
    logic [PWSR_NUM_IRQ-1:0]  int_stat_nxt;
    logic [PWSR_NUM_IRQ-1:0]  int_mask_r;
    logic [PWSR_NUM_IRQ-1:0]  int_mask_nxt;

    // Only the low half carries fields, so only a low-lane write has effect.
    assign wr_lo  = dp_valid_r && dp_write_r && dp_lanes_r[0];
    assign wr_ctl = wr_lo && (dp_addr_r == PWSR_CTL_OFF);
    assign wr_sts = wr_lo && (dp_addr_r == PWSR_STATUS_OFF);
    assign wr_ist = wr_lo && (dp_addr_r == PWSR_INT_STAT_OFF);
    assign wr_imk = wr_lo && (dp_addr_r == PWSR_INT_MASK_OFF);

    // standby clear on write of one
    assign clr_stb  = wr_ctl && hwdata[PWSR_STB_CLR_BIT];
    // wake clear on write of one
    assign clr_wake = wr_ctl && hwdata[PWSR_WAKE_CLR_BIT];

    always_comb
    begin
        gated          = pin_en_r & pins_s;
        pin_evt        = gated & ~gated_prev_r;
        gated_prev_nxt = gated;
        wake_evt       = (|pin_evt) || rtc_wake_evt;
        stb_evt        = standby_in && !stb_prev_r;
        stb_prev_nxt   = standby_in;
        lvd_flag_nxt   = standby_in ? lvd_flag_r : lvd_s;
        lvd_evt        = lvd_flag_nxt && !lvd_flag_r;
        // a new event wins over clear
        wake_flag_nxt  = wake_evt || (wake_flag_r && !clr_wake);
        stb_flag_nxt   = stb_evt || (stb_flag_r && !clr_stb);
        sys_wake_nxt   = wake_evt;
        pin_en_nxt     = pin_en_r;
        if (wr_sts)
        begin
            for (int i = 0; i < NUM_PINS; i++)
                pin_en_nxt[i] = hwdata[PWSR_PIN_EN_BIT[i]];
        end
        evts                  = '0;
        evts[PWSR_IRQ_WAKE]   = wake_evt;
        evts[PWSR_IRQ_STB]    = stb_evt;
        evts[PWSR_IRQ_LVD]    = lvd_evt;
        int_stat_nxt          = evts | (int_stat_r & ~(wr_ist ? hwdata[PWSR_NUM_IRQ-1:0] : PWSR_INT_RST));
        int_mask_nxt          = wr_imk ? hwdata[PWSR_NUM_IRQ-1:0] : int_mask_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_en_r     <= PWSR_PIN_EN_RST;
            gated_prev_r <= '0;
            wake_flag_r  <= PWSR_STATUS_RST[PWSR_WAKE_BIT];
            stb_flag_r   <= PWSR_STATUS_RST[PWSR_STB_BIT];
            stb_prev_r   <= 1'b0;
            lvd_flag_r   <= PWSR_STATUS_RST[PWSR_LVD_BIT];
            sys_wake_r   <= 1'b0;
            int_stat_r   <= PWSR_INT_RST;
            int_mask_r   <= PWSR_INT_RST;
        end
        else
        begin
            pin_en_r     <= pin_en_nxt;
            gated_prev_r <= gated_prev_nxt;
            wake_flag_r  <= wake_flag_nxt;
            stb_flag_r   <= stb_flag_nxt;
            stb_prev_r   <= stb_prev_nxt;
            lvd_flag_r   <= lvd_flag_nxt;
            sys_wake_r   <= sys_wake_nxt;
            int_stat_r   <= int_stat_nxt;
            int_mask_r   <= int_mask_nxt;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic [31:0] rd_word;

    // Read data is taken from next values so a write just before is seen.
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0] & PWSR_WORD_MASK)
            PWSR_STATUS_OFF:
            begin
                for (int i = 0; i < NUM_PINS; i++)
                    rd_word[PWSR_PIN_EN_BIT[i]] = pin_en_nxt[i];
                rd_word[PWSR_LVD_BIT]  = lvd_flag_nxt;
                rd_word[PWSR_STB_BIT]  = stb_flag_nxt;
                rd_word[PWSR_WAKE_BIT] = wake_flag_nxt;
            end
            PWSR_INT_STAT_OFF: rd_word[PWSR_NUM_IRQ-1:0] = int_stat_nxt;
            PWSR_INT_MASK_OFF: rd_word[PWSR_NUM_IRQ-1:0] = int_mask_nxt;
            default:           rd_word = 32'h0000_0000;
        endcase
        hrdata_nxt = (addr_ok && !hwrite) ? rd_word : hrdata_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else
            hrdata_r <= hrdata_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hrdata               = hrdata_r;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign wake_pin_pulldown_en = pin_en_r;
    assign lvd_run              = !standby_in;
    assign sys_wake             = sys_wake_r;
    assign irq                  = |(int_stat_r & int_mask_r);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence pin0_armed_low;
        pin_en_r[0] && !pins_s[0];
    endsequence

    sequence pin0_rises;
        pin_en_r[0] && pins_s[0];
    endsequence

    sequence pin0_enabled_high;
        !pin_en_r[0] ##1 (pin_en_r[0] && pins_s[0]);
    endsequence

    property flag_follows(trig, flag);
        trig |=> flag;
    endproperty

    rtc_wake_a: assert property (flag_follows(rtc_wake_evt, wake_flag_r))
        else $error("rtc wake did not set wake flag");

    pin_edge_a: assert property (pin0_armed_low ##1 pin0_rises |=> wake_flag_r && sys_wake_r)
        else $error("pin edge did not wake");

    pin_level_a: assert property (pin0_enabled_high |=> wake_flag_r)
        else $error("enable with high pin did not wake");

    wake_clear_a: assert property (clr_wake && !wake_evt |=> !wake_flag_r)
        else $error("wake flag not cleared");

    wake_hold_a: assert property (wake_flag_r && !clr_wake |=> wake_flag_r)
        else $error("wake flag dropped without clear");

    stb_set_a: assert property (!standby_in ##1 standby_in |=> stb_flag_r)
        else $error("standby entry not flagged");

    stb_hold_a: assert property (stb_flag_r && !clr_stb |=> stb_flag_r)
        else $error("standby flag dropped without clear");

    lvd_halt_a: assert property (standby_in |=> $stable(lvd_flag_r))
        else $error("low-voltage flag moved in standby");

    lvd_track_a: assert property (!standby_in |=> lvd_flag_r == $past(lvd_s))
        else $error("low-voltage flag does not track detector");

    pulldown_en_a: assert property (wr_sts |=> wake_pin_pulldown_en[NUM_PINS-1]
        == $past(hwdata[PWSR_PIN_EN_BIT[NUM_PINS-1]]))
        else $error("pull-down differs from written enable bit");

    byte_write_a: assert property (addr_ok && hwrite && hsize == 3'h0 |=> ##1 $stable(pin_en_r))
        else $error("byte write changed enables");

    clr_read_a: assert property (addr_ok && !hwrite && (haddr[7:0] & PWSR_WORD_MASK) == PWSR_CTL_OFF
        |=> hrdata[3:2] == 2'h0)
        else $error("flag clear bits read nonzero");

    irq_clear_a: assert property (wr_ist && hwdata[PWSR_IRQ_WAKE] && !wake_evt
        |=> !int_stat_r[PWSR_IRQ_WAKE])
        else $error("wake interrupt status not cleared by write of one");

endmodule : pwsr_top

`default_nettype wire

// File: design/pwsr_pkg.sv
`default_nettype none

package pwsr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PWSR_CTL_OFF       = 8'h00;
    localparam logic [7:0] PWSR_STATUS_OFF    = 8'h04;
    localparam logic [7:0] PWSR_INT_STAT_OFF  = 8'h08;
    localparam logic [7:0] PWSR_INT_MASK_OFF  = 8'h0c;
    localparam logic [7:0] PWSR_WORD_MASK     = 8'hfc;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned PWSR_NUM_PINS      = 4;
    localparam int unsigned PWSR_PIN_EN_BIT [PWSR_NUM_PINS] = '{8, 9, 13, 14};
    localparam int unsigned PWSR_LVD_BIT       = 2;
    localparam int unsigned PWSR_STB_BIT       = 1;
    localparam int unsigned PWSR_WAKE_BIT      = 0;
    localparam int unsigned PWSR_STB_CLR_BIT   = 3;
    localparam int unsigned PWSR_WAKE_CLR_BIT  = 2;
    localparam int unsigned PWSR_IRQ_WAKE      = 0;
    localparam int unsigned PWSR_IRQ_STB       = 1;
    localparam int unsigned PWSR_IRQ_LVD       = 2;
    localparam int unsigned PWSR_NUM_IRQ       = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] PWSR_STATUS_RST   = 32'h0000_0000;
    localparam logic [3:0]  PWSR_PIN_EN_RST   = 4'h0;
    localparam logic [2:0]  PWSR_INT_RST      = 3'h0;

    // ****************************************************************
    // Bus encodings
    // ****************************************************************
    localparam logic [2:0]  PWSR_HSIZE_HALF   = 3'h1;
    localparam logic [2:0]  PWSR_HSIZE_WORD   = 3'h2;
    localparam logic [1:0]  PWSR_LANES_NONE   = 2'h0;
    localparam logic [1:0]  PWSR_LANES_LO     = 2'h1;
    localparam logic [1:0]  PWSR_LANES_HI     = 2'h2;
    localparam logic [1:0]  PWSR_LANES_ALL    = 2'h3;

endpackage : pwsr_pkg

`default_nettype wire

// File: design/pwsr_sync_if.sv
`default_nettype none

interface pwsr_sync_if #(parameter int W = 5);
    logic [W-1:0] async_bits;
    logic [W-1:0] sync_bits;
    modport src  (output async_bits, input sync_bits);
    modport sync (input async_bits, output sync_bits);
endinterface : pwsr_sync_if

`default_nettype wire

// File: design/pwsr_sync.sv
`default_nettype none

module pwsr_sync
    import pwsr_pkg::*;
#(
    parameter int W = 5
)
(
    input wire logic   hclk,
    input wire logic   hresetn,
    pwsr_sync_if.sync  port
);

    if (W < 1)
    begin : g_bad_width
        $error("pwsr_sync needs at least one bit");
    end

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage1_nxt;
    logic [W-1:0] stage2_r;
    logic [W-1:0] stage2_nxt;

    // The first stage feeds only the second stage.
    always_comb
    begin
        stage1_nxt = port.async_bits;
        stage2_nxt = stage1_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign port.sync_bits = stage2_r;

endmodule : pwsr_sync

`default_nettype wire

// File: sim/pwsr_wake_model.sv
`default_nettype none

module pwsr_wake_model
    import pwsr_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic [3:0] pulldown_en,
    output logic      [3:0] wake_pin,
    output logic            rtc_wake_evt,
    output logic            lvd_comp_async,
    output logic            standby_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] drv_en  = 4'hf;
    logic [3:0] drv_val = 4'h0;

    initial
    begin
        rtc_wake_evt   = 1'b0;
        lvd_comp_async = 1'b0;
        standby_in     = 1'b0;
    end

    // pull-down resolution
    // A released pin sits low under its pull-down, otherwise it floats and shows the inverse of its last level.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wake_pin[i] = drv_en[i] ? drv_val[i] : (pulldown_en[i] ? 1'b0 : ~drv_val[i]);
    end

    task automatic set_pin(input int idx, input logic v);
        drv_en[idx]  <= 1'b1;
        drv_val[idx] <= v;
    endtask : set_pin

    task automatic release_pin(input int idx);
        drv_en[idx] <= 1'b0;
    endtask : release_pin

    task automatic rtc_pulse();
        rtc_wake_evt <= 1'b1;
        @(posedge hclk);
        rtc_wake_evt <= 1'b0;
    endtask : rtc_pulse

    task automatic set_lvd(input logic v);
        lvd_comp_async <= v;
    endtask : set_lvd

    task automatic set_standby(input logic v);
        standby_in <= v;
    endtask : set_standby

endmodule : pwsr_wake_model

`default_nettype wire

// File: sim/tb.sv
`default_nettype none

module tb
    import pwsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, lvd_run, sys_wake, irq;
    logic        rtc_wake_evt, lvd_comp_async, standby_in;
    logic [3:0]  wake_pin, pd_en;
    int          mismatches, samples_checked, wake_pulses;

    always #12.5 hclk = ~hclk;

    always @(posedge hclk)
        if (sys_wake === 1'b1)
            wake_pulses++;

    pwsr_top #(.NUM_PINS(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wake_pin(wake_pin), .rtc_wake_evt(rtc_wake_evt),
        .lvd_comp_async(lvd_comp_async), .standby_in(standby_in), .wake_pin_pulldown_en(pd_en),
        .lvd_run(lvd_run), .sys_wake(sys_wake), .irq(irq));

    pwsr_wake_model model_u (.hclk(hclk), .pulldown_en(pd_en), .wake_pin(wake_pin), .rtc_wake_evt(rtc_wake_evt),
        .lvd_comp_async(lvd_comp_async), .standby_in(standby_in));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wait_ready();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        hsize  <= sz;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : bus_write

    task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize  <= PWSR_HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
    endtask : bus_read

    task automatic read_check(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus_read(a, rd);
        check(name, exp, rd);
    endtask : read_check

    task automatic clear_wake();
        bus_write(32'h0, 32'h1 << PWSR_WAKE_CLR_BIT, PWSR_HSIZE_WORD);
    endtask : clear_wake

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    initial
    begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        give_verdict();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        read_check("status reset", 32'h4, 32'h0);
        read_check("mask reset", 32'hc, 32'h0);
        check("pulldown reset", 32'h0, {28'h0, pd_en});
        check("okay resp", 32'h0, {31'h0, hresp});
        check("zero wait", 32'h1, {31'h0, hreadyout});
        $display("test reset done");

        for (int i = 0; i < 4; i++)
        begin
            bus_write(32'h4, 32'h1 << PWSR_PIN_EN_BIT[i], PWSR_HSIZE_WORD);
            read_check("enable bit", 32'h4, 32'h1 << PWSR_PIN_EN_BIT[i]);
            check("pulldown", 32'h1 << i, {28'h0, pd_en});
        end
        bus_write(32'h4, 32'h0000_6300, PWSR_HSIZE_HALF);
        read_check("half write", 32'h4, 32'h0000_6300);
        bus_write(32'h6, 32'h0, PWSR_HSIZE_HALF);
        bus_write(32'h4, 32'h0, 3'h0);
        bus_write(32'h10, 32'h0, PWSR_HSIZE_WORD);
        read_check("refused writes", 32'h4, 32'h0000_6300);
        read_check("unmapped", 32'h10, 32'h0);
        $display("test access done");

        for (int i = 0; i < 4; i++)
        begin
            model_u.set_pin(i, 1'b1);
            repeat (5) @(posedge hclk);
            read_check("pin wake", 32'h4, 32'h0000_6301);
            model_u.set_pin(i, 1'b0);
            bus_write(32'h0, 32'h0, PWSR_HSIZE_WORD);
            read_check("zero clear", 32'h4, 32'h0000_6301);
            clear_wake();
            read_check("wake cleared", 32'h4, 32'h0000_6300);
        end
        check("pulse count", 32'd4, wake_pulses);
        read_check("ctl reads 0", 32'h0, 32'h0);
        $display("test pins done");

        bus_write(32'h4, 32'h0, PWSR_HSIZE_WORD);
        model_u.set_pin(0, 1'b1);
        repeat (5) @(posedge hclk);
        read_check("disabled pin", 32'h4, 32'h0);
        bus_write(32'h4, 32'h0000_6300, PWSR_HSIZE_WORD);
        repeat (5) @(posedge hclk);
        read_check("high at enable", 32'h4, 32'h0000_6301);
        model_u.set_pin(0, 1'b0);
        clear_wake();
        $display("test already high done");

        bus_write(32'h8, 32'h7, PWSR_HSIZE_WORD);
        model_u.rtc_pulse();
        repeat (4) @(posedge hclk);
        read_check("rtc wake", 32'h4, 32'h0000_6301);
        read_check("irq status", 32'h8, 32'h1 << PWSR_IRQ_WAKE);
        @(negedge hclk);
        check("irq masked", 32'h0, {31'h0, irq});
        bus_write(32'hc, 32'h1 << PWSR_IRQ_WAKE, PWSR_HSIZE_WORD);
        @(negedge hclk);
        check("irq raised", 32'h1, {31'h0, irq});
        bus_write(32'h8, 32'h1 << PWSR_IRQ_WAKE, PWSR_HSIZE_WORD);
        @(negedge hclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        clear_wake();
        $display("test rtc irq done");

        model_u.set_lvd(1'b1);
        repeat (5) @(posedge hclk);
        read_check("lvd high", 32'h4, 32'h0000_6304);
        model_u.set_standby(1'b1);
        repeat (3) @(posedge hclk);
        check("lvd halted", 32'h0, {31'h0, lvd_run});
        read_check("standby set", 32'h4, 32'h0000_6306);
        model_u.set_lvd(1'b0);
        repeat (5) @(posedge hclk);
        read_check("lvd frozen", 32'h4, 32'h0000_6306);
        model_u.set_standby(1'b0);
        repeat (5) @(posedge hclk);
        check("lvd running", 32'h1, {31'h0, lvd_run});
        read_check("standby kept", 32'h4, 32'h0000_6302);
        read_check("irq stb lvd", 32'h8, 32'h6);
        bus_write(32'h0, 32'h1 << PWSR_WAKE_CLR_BIT, PWSR_HSIZE_WORD);
        read_check("wrong clear", 32'h4, 32'h0000_6302);
        bus_write(32'h0, 32'h1 << PWSR_STB_CLR_BIT, PWSR_HSIZE_WORD);
        read_check("standby clear", 32'h4, 32'h0000_6300);
        $display("test standby lvd done");
        give_verdict();
    end

endmodule : tb

`default_nettype wire
